// ==== core/ppm_pin_cell.sv ====
// Single pad cell: decodes a two-bit mode into output and enable
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_cell (
    // Control
    input  wire logic [1:0] i_mode,
    input  wire logic       i_value,
    // Pad
    output logic            o_out,
    output logic            o_oe_n
);
    // Quasi and open drain only drive low; push-pull drives both levels
    always_comb begin
        o_out  = i_value;
        o_oe_n = 1'b1;
        case (i_mode)
            ppm_pkg::MODE_QUASI:     o_oe_n = i_value;     // [R01]
            ppm_pkg::MODE_PUSH_PULL: o_oe_n = 1'b0;        // [R01]
            ppm_pkg::MODE_OPEN_DRN:  o_oe_n = i_value;     // [R01]
            ppm_pkg::MODE_INPUT:     o_oe_n = 1'b1;        // [R01]
            default:                 o_oe_n = 1'b1;
        endcase
    end
endmodule : ppm_pin_cell
`default_nettype wire

// ==== core/ppm_port_ctrl.sv ====
// Port mode registers, port 3 latch and alternate-function muxing
//
// Contract
// [R01] Two-bit field per pin: quasi, push-pull, open-drain, input only.
// [R02] Port 1 lower modes at AEh, reset 00h, pins 1.3..1.0 high to low.
// [R03] Port 1 upper modes at AFh, reset 00h, pins 1.7..1.4 high to low.
// [R04] Port 0 upper modes: pins 0.6, 0.5, 0.4 at bits 5-4, 3-2, 1-0.
// [R05] Port 0 also governed by external-access pin and its memory enable.
// [R06] Port 3 latch at B0h, reset FFh, one bit per pin.
// [R07] Software leaves a one in a latch bit before alternate use.
// [R08] Port 3 bit 7 is the active-low external read strobe.
// [R09] Port 3 bit 6 is the active-low external write strobe.
// [R10] External memory selected enables strobes whatever the latch holds.
// [R11] External memory selected overrides port 3 upper modes on strobes.
// [R12] Port 3 bit 5 falling edge counts timer 1.
// [R13] Port 3 bit 0 receives serial data; bidirectional in mode 0.
// [R14] Port 3 bit 4 falling edge counts timer 0.
// [R15] Port 3 bits 3, 2 are external interrupt inputs 1, 0.
// [R16] Port 3 bit 1 sends serial data, or the mode 0 shift clock.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_ctrl (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Special-function register bus
    input  wire ppm_pkg::ppm_sfr_req_t i_sfr,
    output logic [7:0]                o_sfr_rdata,
    output logic                      o_sfr_hit,
    // Memory access control
    input  wire logic                 i_external_access_pin,
    input  wire logic                 i_port0_ext_mem_enable,
    input  wire logic                 i_port2_ext_mem_enable,
    input  wire logic                 i_p0_bus_out,
    input  wire logic [2:0]           i_p0_bus_out_n_unused,
    // Peripheral alternate drive
    input  wire ppm_pkg::ppm_alt_t    i_alt,
    input  wire logic                 i_serial0_mode0,
    input  wire logic [7:0]           i_p0_latch,
    input  wire logic [7:0]           i_p1_latch,
    // Pads: input level, output value, output enable (low drives)
    input  wire logic [2:0]           i_p0_pin,
    input  wire logic [7:0]           i_p1_pin,
    input  wire logic [7:0]           i_p3_pin,
    output logic      [2:0]           o_p0_out,
    output logic      [2:0]           o_p0_oe_n,
    output logic      [7:0]           o_p1_out,
    output logic      [7:0]           o_p1_oe_n,
    output logic      [7:0]           o_p3_out,
    output logic      [7:0]           o_p3_oe_n,
    // Synchronised pin levels to the core
    output logic      [7:0]           o_p1_level,
    output logic      [7:0]           o_p3_level,
    // Peripheral inputs from port 3
    output logic                      o_timer0_count_input,
    output logic                      o_timer1_count_input,
    output logic                      o_ext_irq0_input,
    output logic                      o_ext_irq1_input,
    output logic                      o_ext_irq0_fall,
    output logic                      o_ext_irq1_fall,
    output logic                      o_serial0_receive_pin
);
    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    logic [7:0] p0_upper_modes_r, p0_upper_modes_nxt;
    logic [7:0] port1_lower_pin_modes_r, port1_lower_pin_modes_nxt;
    logic [7:0] port1_upper_pin_modes_r, port1_upper_pin_modes_nxt;
    logic [7:0] port3_data_latch_r, port3_data_latch_nxt;
    logic [7:0] port3_upper_pin_modes_r, port3_upper_pin_modes_nxt;

    // Write decode
    always_comb begin
        p0_upper_modes_nxt        = p0_upper_modes_r;
        port1_lower_pin_modes_nxt = port1_lower_pin_modes_r;
        port1_upper_pin_modes_nxt = port1_upper_pin_modes_r;
        port3_data_latch_nxt      = port3_data_latch_r;
        port3_upper_pin_modes_nxt = port3_upper_pin_modes_r;
        if (i_sfr.wr) begin
            case (i_sfr.addr)
                ppm_pkg::ADDR_P0_UPPER_MODES:
                    p0_upper_modes_nxt = i_sfr.wdata;
                ppm_pkg::ADDR_P1_LOWER_MODES:
                    port1_lower_pin_modes_nxt = i_sfr.wdata; // [R02]
                ppm_pkg::ADDR_P1_UPPER_MODES:
                    port1_upper_pin_modes_nxt = i_sfr.wdata; // [R03]
                ppm_pkg::ADDR_P3_LATCH:
                    port3_data_latch_nxt = i_sfr.wdata;      // [R06]
                ppm_pkg::ADDR_P3_UPPER_MODES:
                    port3_upper_pin_modes_nxt = i_sfr.wdata;
                default: ;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            p0_upper_modes_r        <= ppm_pkg::RST_MODES;
            port1_lower_pin_modes_r <= ppm_pkg::RST_MODES;  // [R02]
            port1_upper_pin_modes_r <= ppm_pkg::RST_MODES;  // [R03]
            port3_data_latch_r      <= ppm_pkg::RST_P3_LATCH; // [R06]
            port3_upper_pin_modes_r <= ppm_pkg::RST_MODES;
        end else begin
            p0_upper_modes_r        <= p0_upper_modes_nxt;
            port1_lower_pin_modes_r <= port1_lower_pin_modes_nxt; // [R02]
            port1_upper_pin_modes_r <= port1_upper_pin_modes_nxt; // [R03]
            port3_data_latch_r      <= port3_data_latch_nxt;    // [R06]
            port3_upper_pin_modes_r <= port3_upper_pin_modes_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [7:0] p3_fall;
    logic [7:0] p1_fall_unused;

    ppm_sync_edge #(.W(8)) u_p3_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_p3_pin),
        .o_level (o_p3_level),
        .o_fall  (p3_fall)
    );

    ppm_sync_edge #(.W(8)) u_p1_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_p1_pin),
        .o_level (o_p1_level),
        .o_fall  (p1_fall_unused)
    );

    // Read mux: latch reads back latch, pins are on o_p3_level
    always_comb begin
        o_sfr_hit   = 1'b1;
        o_sfr_rdata = 8'h0000;
        case (i_sfr.addr)
            ppm_pkg::ADDR_P0_UPPER_MODES: o_sfr_rdata = p0_upper_modes_r;
            ppm_pkg::ADDR_P1_LOWER_MODES: o_sfr_rdata = port1_lower_pin_modes_r;
            ppm_pkg::ADDR_P1_UPPER_MODES: o_sfr_rdata = port1_upper_pin_modes_r;
            ppm_pkg::ADDR_P3_LATCH:       o_sfr_rdata = port3_data_latch_r;
            ppm_pkg::ADDR_P3_UPPER_MODES: o_sfr_rdata = port3_upper_pin_modes_r;
            default:                      o_sfr_hit   = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // Port 1: eight cells, latch value from the core
    // -----------------------------------------------------------------
    logic [15:0] p1_modes;
    assign p1_modes = {port1_upper_pin_modes_r, port1_lower_pin_modes_r};

    for (genvar g = 0; g < 8; g++) begin : g_p1
        ppm_pin_cell u_cell (
            .i_mode  (p1_modes[2*g +: 2]),  // [R02]
            .i_value (i_p1_latch[g]),
            .o_out   (o_p1_out[g]),
            .o_oe_n  (o_p1_oe_n[g])
        );
    end

    // -----------------------------------------------------------------
    // Port 0 upper pins 0.4 to 0.6
    // -----------------------------------------------------------------
    logic       p0_ext_mem;
    logic [2:0] p0_cell_out, p0_cell_oe_n;
    assign p0_ext_mem = ~i_external_access_pin | i_port0_ext_mem_enable;

    for (genvar g = 0; g < 3; g++) begin : g_p0
        ppm_pin_cell u_cell (
            .i_mode  (p0_upper_modes_r[2*g +: 2]),  // [R04]
            .i_value (i_p0_latch[4+g]),
            .o_out   (p0_cell_out[g]),
            .o_oe_n  (p0_cell_oe_n[g])
        );
    end

    // External memory takes the port 0 pins as a bus
    always_comb begin
        o_p0_out  = p0_cell_out;
        o_p0_oe_n = p0_cell_oe_n;
        if (p0_ext_mem) begin                         // [R05]
            o_p0_out  = {3{i_p0_bus_out}} ^ i_p0_bus_out_n_unused;
            o_p0_oe_n = 3'h0;                         // [R05]
        end
    end

    // -----------------------------------------------------------------
    // Port 3 alternate functions
    // -----------------------------------------------------------------
    logic       ext_mem_sel;
    logic [7:0] p3_value;
    logic [7:0] p3_cell_out, p3_cell_oe_n;
    logic [15:0] p3_modes;
    assign ext_mem_sel = p0_ext_mem | i_port2_ext_mem_enable;
    assign p3_modes    = {port3_upper_pin_modes_r, ppm_pkg::RST_MODES};

    // Alternate output ANDs with latch, so a zero latch blocks it
    always_comb begin
        p3_value = port3_data_latch_r;
        p3_value[ppm_pkg::P3_TXD] = port3_data_latch_r[ppm_pkg::P3_TXD]
                                    & i_alt.txd;             // [R16]
        // Receive pin only turns driver in serial mode 0
        p3_value[ppm_pkg::P3_RXD] = port3_data_latch_r[ppm_pkg::P3_RXD]
            & (~(i_alt.rxd_out_en & i_serial0_mode0)
               | i_alt.rxd_out);                              // [R13]
        p3_value[ppm_pkg::P3_RDS] = port3_data_latch_r[ppm_pkg::P3_RDS]
                                    & i_alt.rd_strobe_n;     // [R08]
        p3_value[ppm_pkg::P3_WRS] = port3_data_latch_r[ppm_pkg::P3_WRS]
                                    & i_alt.wr_strobe_n;     // [R09]
    end

    for (genvar g = 0; g < 8; g++) begin : g_p3
        ppm_pin_cell u_cell (
            .i_mode  (p3_modes[2*g +: 2]),
            .i_value (p3_value[g]),
            .o_out   (p3_cell_out[g]),
            .o_oe_n  (p3_cell_oe_n[g])
        );
    end

    // Strobe pins are pushed by the memory interface when selected
    always_comb begin
        o_p3_out  = p3_cell_out;
        o_p3_oe_n = p3_cell_oe_n;
        if (ext_mem_sel) begin
            o_p3_out[ppm_pkg::P3_RDS]  = i_alt.rd_strobe_n;  // [R10]
            o_p3_out[ppm_pkg::P3_WRS]  = i_alt.wr_strobe_n;  // [R10]
            o_p3_oe_n[ppm_pkg::P3_RDS] = 1'b0;               // [R11]
            o_p3_oe_n[ppm_pkg::P3_WRS] = 1'b0;               // [R11]
        end
    end

    // Inputs to timers, interrupts and serial receiver
    assign o_timer0_count_input  = p3_fall[ppm_pkg::P3_CNT0]; // [R14]
    assign o_timer1_count_input  = p3_fall[ppm_pkg::P3_CNT1]; // [R12]
    assign o_ext_irq0_input      = o_p3_level[ppm_pkg::P3_IRQ0]; // [R15]
    assign o_ext_irq1_input      = o_p3_level[ppm_pkg::P3_IRQ1]; // [R15]
    assign o_ext_irq0_fall       = p3_fall[ppm_pkg::P3_IRQ0];  // [R15]
    assign o_ext_irq1_fall       = p3_fall[ppm_pkg::P3_IRQ1];  // [R15]
    assign o_serial0_receive_pin = o_p3_level[ppm_pkg::P3_RXD]; // [R13]

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    p1_reset_a: assert property (@(posedge i_clk) // [R02]
        $rose(i_rst_n) |-> port1_lower_pin_modes_r == ppm_pkg::RST_MODES)
        else $error("port 1 lower modes not cleared by reset");

    p1u_write_a: assert property (@(posedge i_clk) // [R03]
        disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == ppm_pkg::ADDR_P1_UPPER_MODES |=>
        port1_upper_pin_modes_r == $past(i_sfr.wdata))
        else $error("port 1 upper modes write lost");

    latch_write_a: assert property (@(posedge i_clk) // [R06]
        disable iff (!i_rst_n)
        i_sfr.wr && i_sfr.addr == ppm_pkg::ADDR_P3_LATCH |=>
        port3_data_latch_r == $past(i_sfr.wdata))
        else $error("port 3 latch write lost");

    pushpull_a: assert property (@(posedge i_clk) // [R01]
        disable iff (!i_rst_n)
        p1_modes[1:0] == ppm_pkg::MODE_PUSH_PULL |->
        !o_p1_oe_n[0] && o_p1_out[0] == i_p1_latch[0])
        else $error("push-pull pin not driven");

    input_only_a: assert property (@(posedge i_clk) // [R01]
        disable iff (!i_rst_n)
        p1_modes[15:14] == ppm_pkg::MODE_INPUT |-> o_p1_oe_n[7])
        else $error("input-only pin driven");

    strobe_force_a: assert property (@(posedge i_clk) // [R10]
        disable iff (!i_rst_n)
        ext_mem_sel |-> !o_p3_oe_n[7] && o_p3_out[7] == i_alt.rd_strobe_n)
        else $error("read strobe not driven under external memory");

    wr_strobe_a: assert property (@(posedge i_clk) // [R09]
        disable iff (!i_rst_n)
        ext_mem_sel |-> !o_p3_oe_n[6] && o_p3_out[6] == i_alt.wr_strobe_n)
        else $error("write strobe not driven under external memory");

    t1_count_a: assert property (@(posedge i_clk) // [R12]
        disable iff (!i_rst_n)
        $fell(o_p3_level[5]) |-> o_timer1_count_input)
        else $error("timer 1 count missed");

    t0_count_a: assert property (@(posedge i_clk) // [R14]
        disable iff (!i_rst_n)
        o_timer0_count_input |-> $past(o_p3_level[4]) && !o_p3_level[4])
        else $error("timer 0 count without falling edge");

    p0_bus_a: assert property (@(posedge i_clk) // [R05]
        disable iff (!i_rst_n)
        !i_external_access_pin |-> o_p0_oe_n == 3'h0)
        else $error("port 0 not released to bus");

endmodule : ppm_port_ctrl
`default_nettype wire

// ==== core/ppm_sync_edge.sv ====
// Two-flop synchroniser with falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module ppm_sync_edge #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Pins in, synced level and falling pulse out
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] meta_r, sync_r, last_r;

    // Synchroniser stages; resets high as pulled-up pins idle high
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '1;
            sync_r <= '1;
            last_r <= '1;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_fall  = last_r & ~sync_r;
endmodule : ppm_sync_edge
`default_nettype wire

// ==== dv/ppm_pad_model.sv ====
// Pad model: external drivers and pull-ups on one port
`timescale 1ns/1ps
`default_nettype none
module ppm_pad_model #(
    parameter int W = 8
) (
    // Block drive, low enable drives
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe_n,
    // External device drive
    input  wire logic [W-1:0] i_ext_val,
    input  wire logic [W-1:0] i_ext_en,
    // Resolved pin level
    output logic      [W-1:0] o_pin
);
    // ------------------------------------------
    // Wire resolution
    // ------------------------------------------
    // Block wins, then the device; an idle pin floats to the pull-up
    always_comb begin
        for (int k = 0; k < W; k++) begin
            if (!i_oe_n[k])
                o_pin[k] = i_out[k];
            else if (i_ext_en[k])
                o_pin[k] = i_ext_val[k];
            else
                o_pin[k] = 1'b1;
        end
    end
endmodule : ppm_pad_model
`default_nettype wire

// ==== dv/tb_port_pin_mode_and_alt_function.sv ====
// Testbench: register map, pad drive, alternate functions, pin inputs
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_mode_and_alt_function;
    // Row: port 1 low/high modes, port 0 modes, latches
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] p0m;
        logic [7:0] p1v;
        logic [7:0] p0v;
    } ppm_row_t;
    ppm_row_t              rows [4] = '{
        '{8'h1B, 8'hE4, 8'h1B, 8'h55, 8'h50},
        '{8'h1B, 8'hE4, 8'h24, 8'hAA, 8'h20},
        '{8'hFF, 8'h00, 8'h00, 8'h0F, 8'h70},
        '{8'h55, 8'hAA, 8'h3F, 8'hF0, 8'h00}};
    logic [7:0]            lat3 [4] = '{8'hFF, 8'hFF, 8'h3C, 8'h3D};
    logic [4:0]            alts [4] = '{5'h09, 5'h16, 5'h1E, 5'h09};
    logic                  clk, rst_n, xacc, en0, en2, bus, sm0;
    ppm_pkg::ppm_sfr_req_t sfr;
    ppm_pkg::ppm_alt_t     alt;
    logic [7:0]            p0v, p1v, p1pin, p3pin, p3xv, p3xe, rdata, v;
    logic [2:0]            p0o, p0oe, bmask;
    logic [7:0]            p1o, p1oe, p3o, p3oe, p1lev, p3lev;
    logic                  hit, tc0, tc1, q0, q1, f0, f1, rx;
    logic [3:0]            vec, oth;
    int                    err_total, checks_done, cyc, cnt;

    ppm_port_ctrl ppm_port_ctrl_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_sfr(sfr), .o_sfr_rdata(rdata),
        .o_sfr_hit(hit), .i_external_access_pin(xacc),
        .i_port0_ext_mem_enable(en0), .i_port2_ext_mem_enable(en2),
        .i_p0_bus_out(bus), .i_p0_bus_out_n_unused(bmask), .i_alt(alt),
        .i_serial0_mode0(sm0), .i_p0_latch(p0v), .i_p1_latch(p1v),
        .i_p0_pin(3'h0), .i_p1_pin(p1pin), .i_p3_pin(p3pin),
        .o_p0_out(p0o), .o_p0_oe_n(p0oe), .o_p1_out(p1o),
        .o_p1_oe_n(p1oe), .o_p3_out(p3o), .o_p3_oe_n(p3oe),
        .o_p1_level(p1lev), .o_p3_level(p3lev),
        .o_timer0_count_input(tc0), .o_timer1_count_input(tc1),
        .o_ext_irq0_input(q0), .o_ext_irq1_input(q1),
        .o_ext_irq0_fall(f0), .o_ext_irq1_fall(f1),
        .o_serial0_receive_pin(rx));
    ppm_pad_model #(.W(8)) p1_pads_i (.i_out(p1o), .i_oe_n(p1oe),
        .i_ext_val(8'h00), .i_ext_en(8'h00), .o_pin(p1pin));
    ppm_pad_model #(.W(8)) p3_pads_i (.i_out(p3o), .i_oe_n(p3oe),
        .i_ext_val(p3xv), .i_ext_en(p3xe), .o_pin(p3pin));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Compare one value and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Register write, strobe held one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1;
        sfr.wr = 1'b0;
    endtask : wr

    // Combinational read with hit flag, looked at one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic h);
        @(posedge clk);
        #1;
        sfr.addr = a;
        @(posedge clk);
        #1;
        chk(rdata, e);
        chk(8'(hit), 8'(h));
    endtask : rd

    // Expected pad drive from two-bit modes and values
    task automatic pads(input logic [15:0] m, input logic [7:0] val,
                        input logic [7:0] oe, input logic [7:0] o,
                        input int n);
        logic [7:0] eoe;
        logic [7:0] eo;
        #1;
        eoe = 8'h00;
        eo = 8'h00;
        for (int k = 0; k < n; k++) begin
            eoe[k] = (m[2*k+:2] == 2'h3) | ((m[2*k+:2] != 2'h1) & val[k]);
            eo[k] = (m[2*k+:2] == 2'h1) & val[k];
        end
        chk(oe, eoe);
        chk(o & ~oe, eo);
    endtask : pads

    // Reset values, and a refused unmapped write
    task automatic resets;
        wr(8'h12, 8'h5A);
        rd(ppm_pkg::ADDR_P1_LOWER_MODES, 8'h00, 1'b1);
        rd(ppm_pkg::ADDR_P1_UPPER_MODES, 8'h00, 1'b1);
        rd(ppm_pkg::ADDR_P3_LATCH, 8'hFF, 1'b1);
        rd(8'h12, 8'h00, 1'b0);
        chk(p3oe, 8'hFF);
    endtask : resets

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Clock, timeout and sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        {rst_n, en0, en2, bus, sm0, bmask, p0v, p1v, p3xv, p3xe} = '0;
        {sfr, err_total, checks_done} = '0;
        xacc = 1'b1;
        alt = 5'h1E;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        resets();
        // Ordinary cases: port 1 and port 0 modes
        foreach (rows[i]) begin
            p1v = rows[i].p1v;
            p0v = rows[i].p0v;
            wr(ppm_pkg::ADDR_P1_LOWER_MODES, rows[i].lo);
            wr(ppm_pkg::ADDR_P1_UPPER_MODES, rows[i].hi);
            wr(ppm_pkg::ADDR_P0_UPPER_MODES, rows[i].p0m);
            pads({rows[i].hi, rows[i].lo}, p1v, p1oe, p1o, 8);
            pads({10'h000, rows[i].p0m[5:0]}, {5'h00, p0v[6:4]},
                 {5'h00, p0oe}, {5'h00, p0o}, 3);
            rd(ppm_pkg::ADDR_P1_LOWER_MODES, rows[i].lo, 1'b1);
            rd(ppm_pkg::ADDR_P1_UPPER_MODES, rows[i].hi, 1'b1);
            rd(ppm_pkg::ADDR_P0_UPPER_MODES, rows[i].p0m, 1'b1);
            chk(p1lev, p1o | p1oe);
        end
        // Port 3 alternate outputs gated by the latch and serial mode 0
        wr(ppm_pkg::ADDR_P3_UPPER_MODES, 8'h5A);
        rd(ppm_pkg::ADDR_P3_UPPER_MODES, 8'h5A, 1'b1);
        for (int s = 0; s < 4; s++) begin
            alt = alts[s];
            sm0 = (s == 0);
            wr(ppm_pkg::ADDR_P3_LATCH, lat3[s]);
            v = lat3[s] & {alt.rd_strobe_n, alt.wr_strobe_n, 4'hF, alt.txd,
                           (alt.rxd_out_en & sm0) ? alt.rxd_out : 1'b1};
            pads({8'h5A, 8'h00}, v, p3oe, p3o, 8);
            rd(ppm_pkg::ADDR_P3_LATCH, lat3[s], 1'b1);
        end
        // External memory: each selection, latch low, modes input
        wr(ppm_pkg::ADDR_P3_UPPER_MODES, 8'hF0);
        for (int s = 0; s < 6; s++) begin
            @(posedge clk);
            #1;
            xacc = (s / 2) != 0;
            en0 = (s / 2) == 1;
            en2 = (s / 2) == 2;
            bus = s[0];
            bmask = 3'(s);
            alt.rd_strobe_n = s[0];
            alt.wr_strobe_n = ~s[0];
            @(posedge clk);
            #1;
            chk(8'(p3oe[7:6]), 8'h00);
            chk(8'(p0oe), (s < 4) ? 8'h00 : 8'h07);
            chk(8'(p0o), (s < 4) ? 8'({3{s[0]}} ^ 3'(s)) : 8'h00);
            chk(8'(p3o[7:6]), 8'({s[0], ~s[0]}));
        end
        {xacc, en0, en2} = 3'h4;
        alt = 5'h1E;
        // Falling edges on the count and interrupt pins
        wr(ppm_pkg::ADDR_P3_LATCH, 8'hFF);
        wr(ppm_pkg::ADDR_P3_UPPER_MODES, 8'h00);
        for (int k = 0; k < 4; k++) begin
            cnt = 0;
            oth = 4'h0;
            p3xe = 8'(8'h04 << k);
            repeat (8) begin
                @(posedge clk);
                #1;
                vec = {tc1, tc0, f1, f0};
                cnt += vec[k];
                oth |= vec & ~(4'h1 << k);
            end
            chk(8'(cnt), 8'h01);
            chk(8'(oth), 8'h00);
            chk(8'({q1, q0}), 8'(k < 2 ? 2'h3 ^ (2'h1 << k) : 2'h3));
            chk(p3lev, ~p3xe);
            p3xe = 8'h00;
            repeat (4) @(posedge clk);
            #1;
        end
        p3xe = 8'h01;
        repeat (4) @(posedge clk);
        #1 chk(8'(rx), 8'h00);
        p3xe = 8'h00;
        // Reset in mid-run returns port 1 modes and port 3 latch
        wr(ppm_pkg::ADDR_P1_LOWER_MODES, 8'hA5);
        wr(ppm_pkg::ADDR_P3_LATCH, 8'h00);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        resets();
        give_verdict();
    end
endmodule : tb_port_pin_mode_and_alt_function
`default_nettype wire

// ==== include/ppm_pkg.sv ====
// Package: register map, mode codes and signal groups of the port pin block
package ppm_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_P0_UPPER_MODES = 8'h00AD;
    localparam logic [7:0] ADDR_P1_LOWER_MODES = 8'h00AE;
    localparam logic [7:0] ADDR_P1_UPPER_MODES = 8'h00AF;
    localparam logic [7:0] ADDR_P3_LATCH       = 8'h00B0;
    localparam logic [7:0] ADDR_P3_UPPER_MODES = 8'h00B4;
    localparam logic [7:0] RST_MODES           = 8'h0000;
    localparam logic [7:0] RST_P3_LATCH        = 8'h00FF;

    // -----------------------------------------------------------------
    // Pin mode codes (high bit, low bit)
    // -----------------------------------------------------------------
    localparam logic [1:0] MODE_QUASI     = 2'h0;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
    localparam logic [1:0] MODE_OPEN_DRN  = 2'h2;
    localparam logic [1:0] MODE_INPUT     = 2'h3;

    // -----------------------------------------------------------------
    // Port 3 bit positions
    // -----------------------------------------------------------------
    localparam int P3_RXD = 0;
    localparam int P3_TXD = 1;
    localparam int P3_IRQ0 = 2;
    localparam int P3_IRQ1 = 3;
    localparam int P3_CNT0 = 4;
    localparam int P3_CNT1 = 5;
    localparam int P3_WRS = 6;
    localparam int P3_RDS = 7;

    // Register write strobe group
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppm_sfr_req_t;

    // Alternate function drive from peripherals (value, use)
    typedef struct packed {
        logic rd_strobe_n;
        logic wr_strobe_n;
        logic txd;
        logic rxd_out;
        logic rxd_out_en;
    } ppm_alt_t;

endpackage : ppm_pkg
